// ==== hw/epfifo_cfg.svh ====
`ifndef EPFIFO_CFG_SVH
`define EPFIFO_CFG_SVH

// register offsets on the processor port
`define ADDR_W 10
`define OFS_MAXP 10'h204
`define OFS_COUNT 10'h21c
`define OFS_STATUS 10'h21e
`define OFS_DATA 10'h220
`define OFS_CTRL 10'h228
`define OFS_INDEX 10'h22c

// control function bits
`define CTRL_VALIDATE_BIT 3
`define CTRL_CLEAR_BIT 4

// field widths
`define MAXP_W 11
`define COUNT_W 16
`define PTR_W 11
`define SLOT_W 3
`define SLOT_MAX 8

// reset values
`define COUNT_RESET 16'h0000
`define DATA_RESET 32'h00000000
`define STATUS_RESET 8'h00

// fill status codes
`define FILL_NONE 2'b00
`define FILL_ONE 2'b01
`define FILL_BOTH 2'b11

// data window step in bytes per access
`define STEP_16 11'h002
`define STEP_32 11'h004

// processor-side waits, kept for the bench
`define CLK_PERIOD_PS 8000
`define FIRST_READ_WAIT_NS 500
`define FIRST_READ_WAIT_CYC ((`FIRST_READ_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STATUS_WAIT_NS 200
`define STATUS_WAIT_CYC ((`STATUS_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== hw/epfifo_pkg.sv ====
`include "epfifo_cfg.svh"

package epfifo_pkg;

  // one processor access, wr and rd are one-cycle strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } cpu_req_type;

  // serial engine events and byte port
  typedef struct packed {
    logic usb_rst;
    logic in_sent;
    logic out_ack;
    logic [`SLOT_W-1:0] slot;
    logic [`PTR_W-1:0] out_len;
    logic byte_we;
    logic [`PTR_W-1:0] byte_addr;
    logic [7:0] byte_data;
  } eng_req_type;

  // per endpoint slot bookkeeping
  typedef struct packed {
    logic [`MAXP_W-1:0] maxp;
    logic [`COUNT_W-1:0] count;
    logic [`PTR_W-1:0] wptr;
    logic [`PTR_W-1:0] rptr;
    logic [1:0] fill;
    logic cpu_buf;
    logic eng_buf;
    logic [1:0][`PTR_W-1:0] len;
  } slot_type;

  // whole state of the port logic
  typedef struct packed {
    slot_type [`SLOT_MAX-1:0] slot;
    logic [`SLOT_W-1:0] index;
    logic [31:0] rdata;
    logic [7:0] eng_rdata;
    logic [`PTR_W-1:0] eng_len;
    logic [`SLOT_MAX-1:0] ready;
  } state_type;

endpackage

// ==== hw/sync2.sv ====
`timescale 1ns/1ps

// two-stage synchroniser for pin levels
module sync2 #(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // level in and out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [1:0][WIDTH-1:0] s; // stage 0 feeds only stage 1

  // shift the pin through both stages
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= {s[0], d_i};
    end
  end

  assign q_o = s[1];
endmodule

// ==== hw/byte_store.sv ====
`timescale 1ns/1ps

// byte storage for all endpoint buffers
module byte_store #(
  parameter int AW = 10
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // processor side, 2 or 4 bytes written and 4 bytes read from an aligned base
  input wire logic cpu_we_i,
  input wire logic cpu_wide_i,
  input wire logic [AW-1:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic [31:0] cpu_rdata_o,
  // engine side, one byte
  input wire logic eng_we_i,
  input wire logic [AW-1:0] eng_addr_i,
  input wire logic [7:0] eng_wdata_i,
  output logic [7:0] eng_rdata_o
);
  logic [7:0] mem [2**AW]; // flip-flop storage

  // writes, processor lanes last so they win a collision
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 2**AW; i++)
        mem[i] <= 8'h00;
    end
    else
    begin
      if (eng_we_i)
        mem[eng_addr_i] <= eng_wdata_i;
      if (cpu_we_i)
        for (int k = 0; k < 4; k++)
          if (cpu_wide_i || k < 2)
            mem[cpu_addr_i + AW'(k)] <= cpu_wdata_i[8*k +: 8];
    end
  end

  // read lanes, lowest address on the lowest lane
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      cpu_rdata_o[8*k +: 8] = mem[cpu_addr_i + AW'(k)];
    eng_rdata_o = mem[eng_addr_i];
  end
endmodule

// ==== hw/endpoint_fifo_data_port.sv ====
`timescale 1ns/1ps
`include "epfifo_cfg.svh"

// What this block does, with the processor waits of R08, R17 and R18 kept by the bench
// R01: processor reaches FIFO of indexed endpoint
// R02: IN write steps pointer two or four
// R03: OUT read steps pointer two or four
// R04: IN buffer validates itself when full
// R05: force_validate sends a short IN buffer
// R06: fully read OUT buffer clears itself
// R07: force_clear discards the indexed buffer
// R08: processor waits before first data read
// R09: max size write loads byte count
// R10: processor may write a smaller count
// R11: bus reset zeroes the byte count
// R12: IN validates when count reached
// R13: count validation only for processor access
// R14: OUT ack loads count with length
// R15: odd last byte on low lane
// R16: fill status follows the endpoint index
// R17: wait after IN write before status
// R18: wait after OUT event before status
// R19: fill bits read-only, zero after resets
// R20: fill code 00, 01, 11
module endpoint_fifo_data_port #(
  parameter int NUM_SLOT = `SLOT_MAX,
  parameter int BUF_BYTES = 64
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // processor register port
  input wire epfifo_pkg::cpu_req_type cpu_req_i,
  output logic [31:0] rdata_o,
  // width strap pin, high for a 16-bit window
  input wire logic bus16_i,
  // serial engine side
  input wire epfifo_pkg::eng_req_type eng_req_i,
  output logic [7:0] eng_rdata_o,
  output logic [`PTR_W-1:0] eng_len_o,
  output logic [`SLOT_MAX-1:0] ready_o
);
  import epfifo_pkg::*;

  localparam int BYTE_W = $clog2(BUF_BYTES);
  localparam int MEM_AW = `SLOT_W + 1 + BYTE_W;
  localparam logic [`SLOT_W:0] SLOTS = (`SLOT_W + 1)'(NUM_SLOT);
  localparam logic [`PTR_W-1:0] BUF_LIM = `PTR_W'(BUF_BYTES);

  // refuse shapes the storage cannot serve
  if (NUM_SLOT < 2 || NUM_SLOT > `SLOT_MAX || BUF_BYTES < 4 || BUF_BYTES > 1024 ||
      (BUF_BYTES & (BUF_BYTES - 1)) != 0)
  begin : bad_shape
    $error("endpoint_fifo_data_port: unsupported NUM_SLOT or BUF_BYTES");
  end

  // largest packet that one buffer can take
  function automatic logic [`PTR_W-1:0] limit_of(input logic [`MAXP_W-1:0] maxp);
    logic [`PTR_W-1:0] m;
    m = `PTR_W'(maxp);
    return (m > BUF_LIM) ? BUF_LIM : m;
  endfunction

  // blank lanes past the packet end or above a 16-bit window
  function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [`PTR_W-1:0] rp,
                                            input logic [`PTR_W-1:0] len, input logic m16);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < 4; k++)
      if (rp + `PTR_W'(k) < len && !(m16 && k > 1))
        r[8*k +: 8] = d[8*k +: 8];
    return r;
  endfunction

  // two-bit fill code of a buffer pair
  function automatic logic [1:0] fill_code(input logic [1:0] fill);
    if (fill == 2'd0)
      return `FILL_NONE;
    else if (fill == 2'd1)
      return `FILL_ONE;
    else
      return `FILL_BOTH;
  endfunction

  state_type s; // registered state
  state_type next_s; // next state
  logic bus16; // synchronised width strap
  logic [`SLOT_W-1:0] ix; // indexed slot
  logic [`SLOT_W-1:0] es; // engine slot
  slot_type cur; // indexed slot before this cycle
  logic hit; // index names a present slot
  logic is_in; // indexed slot is an IN endpoint
  logic [`PTR_W-1:0] step; // bytes per window access
  logic [`PTR_W-1:0] nptr; // pointer after this access
  logic vld; // validate the indexed IN buffer
  logic [`PTR_W-1:0] vlen; // length of the validated packet
  logic clr; // drop the indexed buffer
  logic [`SLOT_MAX-1:0] inc; // a buffer became full
  logic [`SLOT_MAX-1:0] dec; // a buffer became free
  logic mem_we; // processor write into storage
  logic [MEM_AW-1:0] cpu_addr; // processor storage address
  logic [MEM_AW-1:0] eng_addr; // engine storage address
  logic [31:0] cpu_word; // raw bytes at the processor address
  logic [7:0] eng_byte; // raw byte at the engine address
  logic wr_data; // processor writes the data window
  logic rd_data; // processor reads the data window

  // width strap passes two flops
  sync2 #(
    .WIDTH(1)
  ) width_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(bus16_i),
    .q_o(bus16)
  );

  // buffer storage
  byte_store #(
    .AW(MEM_AW)
  ) store (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .cpu_we_i(mem_we),
    .cpu_wide_i(!bus16),
    .cpu_addr_i(cpu_addr),
    .cpu_wdata_i(cpu_req_i.wdata),
    .cpu_rdata_o(cpu_word),
    .eng_we_i(eng_req_i.byte_we),
    .eng_addr_i(eng_addr),
    .eng_wdata_i(eng_req_i.byte_data),
    .eng_rdata_o(eng_byte)
  );

  // all next-state decisions
  always_comb
  begin
    next_s = s;
    inc = '0;
    dec = '0;
    vld = 1'b0;
    vlen = '0;
    clr = 1'b0;
    ix = s.index;
    es = eng_req_i.slot;
    cur = s.slot[ix];
    hit = {1'b0, ix} < SLOTS;
    is_in = ix[0];
    step = bus16 ? `STEP_16 : `STEP_32;
    wr_data = cpu_req_i.wr && cpu_req_i.addr == `OFS_DATA && hit;
    rd_data = cpu_req_i.rd && cpu_req_i.addr == `OFS_DATA && hit;
    nptr = (wr_data ? cur.wptr : cur.rptr) + step; // [R02] [R03]
    mem_we = wr_data && is_in && cur.fill != 2'd2;
    cpu_addr = {ix, cur.cpu_buf, (wr_data ? cur.wptr[BYTE_W-1:0] : cur.rptr[BYTE_W-1:0])};
    eng_addr = {es, s.slot[es].eng_buf, eng_req_i.byte_addr[BYTE_W-1:0]};
    // engine sent the oldest validated IN buffer
    if (eng_req_i.in_sent && es[0] && s.slot[es].fill != 2'd0)
    begin
      dec[es] = 1'b1;
      next_s.slot[es].eng_buf = !s.slot[es].eng_buf;
    end
    // engine acknowledged an OUT packet
    if (eng_req_i.out_ack && !es[0] && s.slot[es].fill != 2'd2)
    begin
      inc[es] = 1'b1;
      next_s.slot[es].len[s.slot[es].eng_buf] = eng_req_i.out_len;
      next_s.slot[es].count = `COUNT_W'(eng_req_i.out_len); // [R14]
      next_s.slot[es].eng_buf = !s.slot[es].eng_buf;
    end
    // byte and length seen by the engine
    next_s.eng_rdata = eng_byte;
    next_s.eng_len = s.slot[es].len[s.slot[es].eng_buf];
    // processor writes
    if (cpu_req_i.wr)
    begin
      if (cpu_req_i.addr == `OFS_INDEX)
      begin
        next_s.index = cpu_req_i.wdata[`SLOT_W-1:0];
      end
      else if (cpu_req_i.addr == `OFS_MAXP && hit)
      begin
        next_s.slot[ix].maxp = cpu_req_i.wdata[`MAXP_W-1:0];
        next_s.slot[ix].count = `COUNT_W'(cpu_req_i.wdata[`MAXP_W-1:0]); // [R09]
      end
      else if (cpu_req_i.addr == `OFS_COUNT && hit)
      begin
        next_s.slot[ix].count = cpu_req_i.wdata[`COUNT_W-1:0]; // [R10]
      end
      else if (cpu_req_i.addr == `OFS_CTRL && hit)
      begin
        // clear wins over validate in the same write
        if (cpu_req_i.wdata[`CTRL_CLEAR_BIT])
          clr = 1'b1; // [R07]
        else if (cpu_req_i.wdata[`CTRL_VALIDATE_BIT] && is_in && cur.fill != 2'd2)
        begin
          vld = 1'b1; // [R05]
          vlen = cur.wptr;
        end
      end
      else if (mem_we)
      begin
        // bytes go to the buffer the processor owns
        next_s.slot[ix].wptr = nptr; // [R01] [R02]
        if (nptr >= limit_of(cur.maxp) ||
            (cur.count != '0 && {5'h00, nptr} >= cur.count)) // [R04] [R12] [R13]
        begin
          vld = 1'b1;
          vlen = (nptr > BUF_LIM) ? BUF_LIM : nptr;
        end
      end
    end
    // processor reads, unmapped offsets read zero
    else if (cpu_req_i.rd)
    begin
      if (rd_data && !is_in && cur.fill != 2'd0)
      begin
        next_s.rdata = lane_mask(cpu_word, cur.rptr, cur.len[cur.cpu_buf], bus16); // [R01] [R15]
        next_s.slot[ix].rptr = nptr; // [R03]
        if (nptr >= cur.len[cur.cpu_buf])
          clr = 1'b1; // [R06]
      end
      else if (cpu_req_i.addr == `OFS_STATUS && hit)
        next_s.rdata = {24'h000000, 6'h00, fill_code(cur.fill)}; // [R16] [R19] [R20]
      else if (cpu_req_i.addr == `OFS_COUNT && hit)
        next_s.rdata = {16'h0000, cur.count};
      else if (cpu_req_i.addr == `OFS_MAXP && hit)
        next_s.rdata = {21'h000000, cur.maxp};
      else if (cpu_req_i.addr == `OFS_INDEX)
        next_s.rdata = {29'h00000000, ix};
      else
        next_s.rdata = `DATA_RESET;
    end
    // hand a validated IN buffer, full or short, to the engine
    if (vld)
    begin
      inc[ix] = 1'b1;
      next_s.slot[ix].len[cur.cpu_buf] = vlen;
      next_s.slot[ix].cpu_buf = !cur.cpu_buf;
      next_s.slot[ix].wptr = '0;
    end
    // drop the buffer the processor owns
    if (clr)
    begin
      if (is_in)
        next_s.slot[ix].wptr = '0;
      else if (cur.fill != 2'd0)
      begin
        dec[ix] = 1'b1;
        next_s.slot[ix].cpu_buf = !cur.cpu_buf;
        next_s.slot[ix].rptr = '0;
      end
    end
    // fill counts, a fill and a drain together cancel
    for (int i = 0; i < `SLOT_MAX; i++)
    begin
      next_s.slot[i].fill = s.slot[i].fill + {1'b0, inc[i]} - {1'b0, dec[i]};
      next_s.ready[i] = (i[0] ? next_s.slot[i].fill != 2'd0 : next_s.slot[i].fill != 2'd2)
                        && i < NUM_SLOT;
    end
    // bus reset empties buffers but keeps sizes
    if (eng_req_i.usb_rst)
    begin
      for (int i = 0; i < `SLOT_MAX; i++)
      begin
        next_s.slot[i].count = `COUNT_RESET; // [R11]
        next_s.slot[i].fill = 2'd0; // [R19]
        next_s.slot[i].wptr = '0;
        next_s.slot[i].rptr = '0;
        next_s.slot[i].cpu_buf = 1'b0;
        next_s.slot[i].eng_buf = 1'b0;
        next_s.ready[i] = i[0] ? 1'b0 : i < NUM_SLOT;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign rdata_o = s.rdata;
  assign eng_rdata_o = s.eng_rdata;
  assign eng_len_o = s.eng_len;
  assign ready_o = s.ready;

  // checks on the port behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic quiet; // no engine event or bus reset this cycle
  assign quiet = !eng_req_i.usb_rst && !eng_req_i.in_sent && !eng_req_i.out_ack;

  step_in_a: assert property (mem_we && !vld && quiet |=> // [R02]
    s.slot[$past(ix)].wptr == $past(cur.wptr) + $past(step))
    else $error("IN write pointer step wrong");
  // a write in the same cycle takes priority, so reads are checked alone
  step_out_a: assert property (rd_data && !cpu_req_i.wr && !is_in && cur.fill != 2'd0 && // [R03]
    !clr && quiet |=> s.slot[$past(ix)].rptr == $past(cur.rptr) + $past(step))
    else $error("OUT read pointer step wrong");
  full_valid_a: assert property (mem_we && quiet && nptr >= limit_of(cur.maxp) |=> // [R04]
    s.slot[$past(ix)].fill == $past(cur.fill) + 2'd1 && s.slot[$past(ix)].wptr == '0)
    else $error("full IN buffer not validated");
  force_valid_a: assert property (vld && cpu_req_i.addr == `OFS_CTRL && quiet |=> // [R05]
    s.slot[$past(ix)].len[$past(cur.cpu_buf)] == $past(cur.wptr))
    else $error("forced validate length wrong");
  auto_clear_a: assert property (rd_data && !cpu_req_i.wr && !is_in && cur.fill != 2'd0 && // [R06]
    quiet && nptr >= cur.len[cur.cpu_buf] |=> s.slot[$past(ix)].fill == $past(cur.fill) - 2'd1)
    else $error("read-out OUT buffer not cleared");
  force_clear_a: assert property (clr && !is_in && cur.fill != 2'd0 && quiet |=> // [R07]
    s.slot[$past(ix)].rptr == '0 && s.slot[$past(ix)].fill == $past(cur.fill) - 2'd1 &&
    ready_o[$past(ix)])
    else $error("forced clear left OUT buffer");
  maxp_load_a: assert property (cpu_req_i.wr && cpu_req_i.addr == `OFS_MAXP && hit && // [R09]
    quiet |=> s.slot[$past(ix)].count == `COUNT_W'($past(cpu_req_i.wdata[`MAXP_W-1:0])))
    else $error("count not loaded from size");
  count_write_a: assert property (cpu_req_i.wr && cpu_req_i.addr == `OFS_COUNT && hit && // [R10]
    quiet |=> s.slot[$past(ix)].count == $past(cpu_req_i.wdata[`COUNT_W-1:0]))
    else $error("count write lost");
  bus_reset_a: assert property (eng_req_i.usb_rst |=> // [R11] [R19]
    s.slot[$past(ix)].count == `COUNT_RESET && s.slot[$past(ix)].fill == 2'd0)
    else $error("bus reset left count or fill");
  // a processor count write in the same cycle overrides the engine
  out_count_a: assert property (eng_req_i.out_ack && !es[0] && s.slot[es].fill != 2'd2 && // [R14]
    !eng_req_i.usb_rst && !cpu_req_i.wr |=>
    s.slot[$past(es)].count == `COUNT_W'($past(eng_req_i.out_len)))
    else $error("OUT count not loaded");
  status_read_a: assert property (cpu_req_i.rd && !cpu_req_i.wr && // [R16] [R20]
    cpu_req_i.addr == `OFS_STATUS && hit |=>
    rdata_o == {30'h00000000, $past(fill_code(cur.fill))})
    else $error("fill status read wrong");
  odd_lane_a: assert property (rd_data && !cpu_req_i.wr && bus16 && !is_in && // [R15]
    cur.fill != 2'd0 && cur.rptr + `PTR_W'(1) == cur.len[cur.cpu_buf] |=>
    rdata_o[15:8] == 8'h00)
    else $error("odd last byte not on low lane");

  in_full_c: cover property (mem_we && vld ##[1:20] eng_req_i.in_sent);
  out_drain_c: cover property (eng_req_i.out_ack && !es[0] ##[1:100] (rd_data && clr));
  both_full_c: cover property (cur.fill == 2'd2 && hit);
  short_pkt_c: cover property (mem_we && vld && nptr < limit_of(cur.maxp));
endmodule

// ==== dv/usb_engine_model.sv ====
`timescale 1ns/1ps
`include "epfifo_cfg.svh"

// serial engine stand-in: fills OUT buffers, acks them, sends IN buffers
module usb_engine_model
(
  // clock
  input wire logic clk_i,
  // engine events into the port logic
  output epfifo_pkg::eng_req_type eng_o
);
  import epfifo_pkg::*;

  // quiet engine at time zero
  initial
  begin
    eng_o = '0;
  end

  // byte-wise fill of an OUT buffer, then the ack with its length
  task automatic out_packet(input logic [2:0] s, input int n, input logic [63:0] d);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      eng_o.slot = s;
      eng_o.byte_we = 1'b1;
      eng_o.byte_addr = 11'(i);
      eng_o.byte_data = d[8*i +: 8];
    end
    @(negedge clk_i);
    eng_o.byte_we = 1'b0;
    // released byte lines do not keep the last value
    eng_o.byte_data = ~eng_o.byte_data;
    eng_o.out_ack = 1'b1;
    eng_o.out_len = 11'(n);
    @(negedge clk_i);
    eng_o.out_ack = 1'b0;
    eng_o.out_len = ~eng_o.out_len;
  endtask

  // one IN token answered with the oldest validated buffer
  task automatic send_in(input logic [2:0] s);
    @(negedge clk_i);
    eng_o.slot = s;
    eng_o.in_sent = 1'b1;
    @(negedge clk_i);
    eng_o.in_sent = 1'b0;
  endtask

  // one cycle of bus reset
  task automatic bus_reset;
    @(negedge clk_i);
    eng_o.usb_rst = 1'b1;
    @(negedge clk_i);
    eng_o.usb_rst = 1'b0;
  endtask
endmodule

// ==== dv/endpoint_fifo_data_port_tb.sv ====
`timescale 1ns/1ps
`include "epfifo_cfg.svh"

// processor-side bench for the endpoint data port
module endpoint_fifo_data_port_tb;
  import epfifo_pkg::*;

  logic clk_i; // 125 MHz clock
  logic rstn_i; // active low reset
  cpu_req_type req; // processor access
  logic [31:0] rdata; // read data
  logic bus16; // width strap
  eng_req_type eng; // engine events
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic rd_seen; // a read was taken at the last edge
  logic [`SLOT_MAX-1:0] ready; // per slot ready
  logic [7:0] eng_rdata; // byte seen by the engine
  logic [`PTR_W-1:0] eng_len; // packet length seen by the engine
  int err_count;
  int samples_checked;
  integer seed;
  logic [63:0] pkt; // random IN or OUT payload

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  endpoint_fifo_data_port dut (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .cpu_req_i(req),
    .rdata_o(rdata),
    .bus16_i(bus16),
    .eng_req_i(eng),
    .eng_rdata_o(eng_rdata),
    .eng_len_o(eng_len),
    .ready_o(ready)
  );

  usb_engine_model model (
    .clk_i(clk_i),
    .eng_o(eng)
  );

  // compare one value
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(negedge clk_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_i);
    req.wr = 1'b0;
    req.wdata = ~d;
  endtask

  // one-cycle read strobe, expectation noted for the monitor
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(negedge clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_i);
    req.rd = 1'b0;
  endtask

  // n random words into the data window
  task automatic wr_in(input int n);
    repeat (n) wr(`OFS_DATA, $random(seed));
  endtask

  // read monitor: data lands at the edge that takes the read
  always @(posedge clk_i)
    rd_seen <= req.rd & ~req.wr;

  always @(negedge clk_i)
  begin
    if (rd_seen === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 32'h0, 32'h1);
      else
        chk("rdata_o", rdata, exp_q.pop_front());
    end
  end

  // main sequence
  initial
  begin
    seed = 32'h2759;
    req = '0;
    bus16 = 1'b0;
    rstn_i = 1'b0;
    cyc(20);
    rstn_i = 1'b1;
    cyc(3);
    // values after reset, unmapped place
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_COUNT, 32'h0);
    rd(10'h100, 32'h0);
    // IN slot 1, 32-bit, full packets
    wr(`OFS_INDEX, 32'h1);
    wr(`OFS_MAXP, 32'h8);
    rd(`OFS_COUNT, 32'h8);
    rd(`OFS_MAXP, 32'h8);
    rd(`OFS_INDEX, 32'h1);
    wr_in(2);
    cyc(`STATUS_WAIT_CYC);
    chk("ready_o in", 32'(ready[1]), 32'h1);
    rd(`OFS_STATUS, `FILL_ONE);
    wr_in(2);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_BOTH);
    wr(`OFS_STATUS, 32'hff);
    rd(`OFS_STATUS, `FILL_BOTH);
    model.send_in(3'h1);
    cyc(2);
    rd(`OFS_STATUS, `FILL_ONE);
    model.send_in(3'h1);
    cyc(2);
    chk("ready_o sent", 32'(ready[1]), 32'h0);
    rd(`OFS_STATUS, `FILL_NONE);
    // short packet by byte count
    wr(`OFS_COUNT, 32'h4);
    rd(`OFS_COUNT, 32'h4);
    wr_in(1);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_ONE);
    model.send_in(3'h1);
    // short packet by force_validate
    wr(`OFS_MAXP, 32'h8);
    wr_in(1);
    wr(`OFS_CTRL, 32'h1 << `CTRL_VALIDATE_BIT);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_ONE);
    model.send_in(3'h1);
    // force_clear drops the unvalidated word
    wr_in(1);
    wr(`OFS_CTRL, 32'h1 << `CTRL_CLEAR_BIT);
    wr_in(1);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_NONE);
    wr_in(1);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_ONE);
    model.send_in(3'h1);
    // 16-bit window: two writes fill a 4-byte packet
    bus16 = 1'b1;
    cyc(4);
    wr(`OFS_MAXP, 32'h4);
    pkt = {$random(seed), $random(seed)};
    wr(`OFS_DATA, pkt[31:0]);
    wr(`OFS_DATA, pkt[63:32]);
    cyc(`STATUS_WAIT_CYC);
    chk("ready_o 16", 32'(ready[1]), 32'h1);
    chk("eng_len_o", 32'(eng_len), 32'h4);
    chk("eng_rdata_o", 32'(eng_rdata), {24'h0, pkt[7:0]});
    model.send_in(3'h1);
    // OUT slot 0, odd packet read through 16-bit window
    wr(`OFS_INDEX, 32'h0);
    pkt = {$random(seed), $random(seed)};
    model.out_packet(3'h0, 5, pkt);
    cyc(`FIRST_READ_WAIT_CYC);
    rd(`OFS_COUNT, 32'h5);
    rd(`OFS_STATUS, `FILL_ONE);
    rd(`OFS_DATA, {16'h0, pkt[15:0]});
    rd(`OFS_DATA, {16'h0, pkt[31:16]});
    rd(`OFS_DATA, {24'h0, pkt[39:32]});
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_NONE);
    // force_clear on a partly read OUT buffer, 2 of its 6 bytes read
    pkt = {$random(seed), $random(seed)};
    model.out_packet(3'h0, 6, pkt);
    cyc(`FIRST_READ_WAIT_CYC);
    rd(`OFS_DATA, {16'h0, pkt[15:0]});
    wr(`OFS_CTRL, 32'h1 << `CTRL_CLEAR_BIT);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_NONE);
    chk("ready_o out", 32'(ready[0]), 32'h1);
    // 32-bit read of a four-byte packet
    bus16 = 1'b0;
    cyc(4);
    pkt = {$random(seed), $random(seed)};
    model.out_packet(3'h0, 4, pkt);
    cyc(`FIRST_READ_WAIT_CYC);
    rd(`OFS_DATA, pkt[31:0]);
    cyc(`STATUS_WAIT_CYC);
    rd(`OFS_STATUS, `FILL_NONE);
    // bus reset clears the byte count
    model.out_packet(3'h0, 3, pkt);
    model.bus_reset();
    cyc(2);
    rd(`OFS_COUNT, 32'h0);
    rd(`OFS_STATUS, `FILL_NONE);
    // bounded drain of pending reads
    for (int i = 0; i < 10 && exp_q.size() != 0; i++)
      cyc(1);
    if (exp_q.size() != 0)
      err_count++;
    test_done();
  end
endmodule
